/* src/pc_stack.sv */
// program counter, return address stack and fast shadow registers with an APB register window
// assumes: decoder presents one flow request per enabled cycle; stack fault reset handled outside
//
// Chosen here: the APB register port and the register addresses.
`default_nettype none
module pc_stack (
	// clock and reset
	input  wire logic                 I_REF_CLK,
	input  wire logic                 I_RESETN,
	input  wire logic                 I_CE,
	// configuration
	input  wire logic                 I_STACK_FAULT_RESET_ENABLE,
	input  wire logic                 I_POR,
	// decoder side
	input  wire pcstk_pkg::flow_req_t I_REQ,
	input  wire pcstk_pkg::core_regs_t I_CORE_REGS,
	output var  logic [20:0]          O_PC,
	output var  logic                 O_RESTORE_VALID,
	output var  pcstk_pkg::core_regs_t O_RESTORE_REGS,
	output var  logic                 O_FAULT_RESET,
	// apb
	input  wire logic                 I_PSEL,
	input  wire logic                 I_PENABLE,
	input  wire logic                 I_PWRITE,
	input  wire logic [7:0]           I_PADDR,
	input  wire logic [31:0]          I_PWDATA,
	output var  logic [31:0]          O_PRDATA,
	output var  logic                 O_PREADY,
	output var  logic                 O_PSLVERR
);
	logic [20:0] pc_q;
	logic [7:0]  hlatch_q;
	logic [4:0]  ulatch_q;
	logic [4:0]  sp_q;
	logic        full_q;
	logic        unf_q;
	logic [20:0] tos_rd;
	pcstk_pkg::core_regs_t shadow_q;
	// apb: first access cycle arms acc_q; answer in the third access cycle via a second wait
	logic        acc_q;

	pcstk_pkg::flow_op_t op;
	assign op = I_REQ.op;

	logic is_push;
	logic is_pop;
	logic hw_stack;
	assign is_push  = (op == pcstk_pkg::OP_CALL) || (op == pcstk_pkg::OP_RELATIVE_CALL) ||
		(op == pcstk_pkg::OP_IRQ) || (op == pcstk_pkg::OP_PUSH);
	assign is_pop   = (op == pcstk_pkg::OP_RETURN) || (op == pcstk_pkg::OP_RETURN_WITH_LITERAL) ||
		(op == pcstk_pkg::OP_RETURN_FROM_INTERRUPT) || (op == pcstk_pkg::OP_POP);
	assign hw_stack = is_push || is_pop;

	// access cycle: register read data is sampled in the second access cycle, once acc_q is set, so tos is settled
	logic apb_go;
	logic wr;
	logic rd;
	assign apb_go = I_PSEL && I_PENABLE && acc_q;
	assign wr     = apb_go && I_PWRITE;
	assign rd     = apb_go && !I_PWRITE;

	logic wr_pcl;
	logic rd_pcl;
	assign wr_pcl = wr && I_PADDR == pcstk_pkg::A_PC_LOW;
	assign rd_pcl = rd && I_PADDR == pcstk_pkg::A_PC_LOW;

	// software writes to the stack window lose to a hardware stack op
	logic sw_sp;
	logic sw_tos;
	assign sw_sp  = wr && !hw_stack && I_PADDR == pcstk_pkg::A_SP;
	assign sw_tos = wr && !hw_stack && sp_q != '0 && (I_PADDR == pcstk_pkg::A_TOS_LOW ||
		I_PADDR == pcstk_pkg::A_TOS_HIGH || I_PADDR == pcstk_pkg::A_TOS_UPPER);

	// push outcome
	logic at_last;
	logic overflow;
	logic [20:0] ret_addr;
	assign at_last  = is_push && sp_q == pcstk_pkg::SP_MAX - 5'h01;
	assign overflow = is_push && sp_q == pcstk_pkg::SP_MAX;
	assign ret_addr = (op == pcstk_pkg::OP_PUSH || op == pcstk_pkg::OP_IRQ) ? pc_q : pc_q + pcstk_pkg::PC_STEP;

	logic underflow;
	assign underflow = is_pop && sp_q == '0;

	logic fault;
	assign fault = I_STACK_FAULT_RESET_ENABLE && (at_last || overflow || underflow);

	// memory write port
	logic        mem_we;
	logic [4:0]  mem_wa;
	logic [20:0] mem_wd;
	always_comb begin
		mem_we = 1'b0;
		mem_wa = sp_q;
		mem_wd = tos_rd;
		if (is_push && !overflow) begin
			mem_we = 1'b1;
			mem_wa = sp_q + 5'h01;
			mem_wd = ret_addr;
		end else if (sw_tos) begin
			mem_we = 1'b1;
			unique case (I_PADDR)
				pcstk_pkg::A_TOS_LOW:  mem_wd = {tos_rd[20:8], I_PWDATA[7:0]};
				pcstk_pkg::A_TOS_HIGH: mem_wd = {tos_rd[20:16], I_PWDATA[7:0], tos_rd[7:0]};
				default:               mem_wd = {I_PWDATA[4:0], tos_rd[15:0]};
			endcase
		end
	end

	logic [4:0] sp_next;
	always_comb begin
		sp_next = sp_q;
		if (is_push && !overflow) begin
			sp_next = sp_q + 5'h01;
		end else if (is_pop && !underflow) begin
			sp_next = sp_q - 5'h01;
		end else if (sw_sp) begin
			sp_next = I_PWDATA[4:0];
		end
		if (fault) begin
			sp_next = '0;
		end
	end

	ret_stack_mem #(
		.DEPTH (pcstk_pkg::STK_DEPTH),
		.WIDTH (pcstk_pkg::PC_W),
		.AW    (pcstk_pkg::SP_W)
	) u_mem (
		.i_clk   (I_REF_CLK),
		.i_ce    (I_CE),
		.i_we    (mem_we),
		.i_waddr (mem_wa),
		.i_wdata (mem_wd),
		.i_raddr (sp_next),
		.o_rdata (tos_rd)
	);

	// stack pointer
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sp_q <= '0;
		end else if (I_CE) begin
			sp_q <= sp_next;
		end
	end

	// flags: set beats software clear; otherwise only power-on or I_RESETN low clears them
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			full_q <= 1'b0;
			unf_q  <= 1'b0;
		end else if (I_CE) begin
			if (I_POR) begin
				full_q <= 1'b0;
				unf_q  <= 1'b0;
			end else begin
				if (at_last || overflow) begin
					full_q <= 1'b1;
				end else if (sw_sp && !I_PWDATA[pcstk_pkg::FULL_BIT]) begin
					full_q <= 1'b0;
				end
				if (underflow) begin
					unf_q <= 1'b1;
				end else if (sw_sp && !I_PWDATA[pcstk_pkg::UNF_BIT]) begin
					unf_q <= 1'b0;
				end
			end
		end
	end

	// program counter
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			pc_q <= pcstk_pkg::PC_RESET;
		end else if (I_CE) begin
			if (fault) begin
				pc_q <= pcstk_pkg::PC_RESET;
			end else begin
				unique case (op)
					pcstk_pkg::OP_STEP, pcstk_pkg::OP_PUSH, pcstk_pkg::OP_POP:
						pc_q <= pc_q + pcstk_pkg::PC_STEP;
					pcstk_pkg::OP_CALL, pcstk_pkg::OP_RELATIVE_CALL, pcstk_pkg::OP_JUMP, pcstk_pkg::OP_BRANCH:
						pc_q <= {I_REQ.target[20:1], 1'b0};
					pcstk_pkg::OP_IRQ:
						pc_q <= I_REQ.irq_high ? pcstk_pkg::VEC_HIGH : pcstk_pkg::VEC_LOW;
					pcstk_pkg::OP_RETURN, pcstk_pkg::OP_RETURN_WITH_LITERAL, pcstk_pkg::OP_RETURN_FROM_INTERRUPT:
						pc_q <= underflow ? '0 : {tos_rd[20:1], 1'b0};
					pcstk_pkg::OP_NONE:
						if (wr_pcl) begin
							pc_q <= {ulatch_q, hlatch_q, I_PWDATA[7:1], 1'b0};
						end
					default: pc_q <= pc_q;
				endcase
			end
		end
	end

	// holding latches; stack ops never touch them
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			hlatch_q <= '0;
			ulatch_q <= '0;
		end else if (I_CE) begin
			if (rd_pcl) begin
				hlatch_q <= pc_q[15:8];
				ulatch_q <= pc_q[20:16];
			end else if (wr && I_PADDR == pcstk_pkg::A_PC_HLATCH) begin
				hlatch_q <= I_PWDATA[7:0];
			end else if (wr && I_PADDR == pcstk_pkg::A_PC_ULATCH) begin
				ulatch_q <= I_PWDATA[4:0];
			end
		end
	end

	// fast shadow registers
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			shadow_q        <= '0;
			O_RESTORE_VALID <= 1'b0;
			O_RESTORE_REGS  <= '0;
		end else if (I_CE) begin
			O_RESTORE_VALID <= 1'b0;
			if (op == pcstk_pkg::OP_IRQ || (op == pcstk_pkg::OP_CALL && I_REQ.fast)) begin
				shadow_q <= I_CORE_REGS;
			end
			if ((op == pcstk_pkg::OP_RETURN_FROM_INTERRUPT || op == pcstk_pkg::OP_RETURN) && I_REQ.fast) begin
				O_RESTORE_VALID <= 1'b1;
				O_RESTORE_REGS  <= shadow_q;
			end
		end
	end

	// fault reset pulse
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_FAULT_RESET <= 1'b0;
		end else if (I_CE) begin
			O_FAULT_RESET <= fault;
		end
	end

	// apb: two wait states, ready in the third access cycle
	logic [31:0] rdata;
	logic        addr_ok;
	always_comb begin
		rdata   = '0;
		addr_ok = 1'b1;
		unique case (I_PADDR)
			pcstk_pkg::A_PC_LOW:    rdata = {24'h000000, pc_q[7:0]};
			pcstk_pkg::A_PC_HLATCH: rdata = {24'h000000, hlatch_q};
			pcstk_pkg::A_PC_ULATCH: rdata = {27'h0000000, ulatch_q};
			pcstk_pkg::A_SP:        rdata = {24'h000000, full_q, unf_q, 1'b0, sp_q};
			pcstk_pkg::A_TOS_LOW:   rdata = {24'h000000, tos_rd[7:0]};
			pcstk_pkg::A_TOS_HIGH:  rdata = {24'h000000, tos_rd[15:8]};
			pcstk_pkg::A_TOS_UPPER: rdata = {27'h0000000, tos_rd[20:16]};
			pcstk_pkg::A_CTRL:      rdata = {31'h00000000, I_STACK_FAULT_RESET_ENABLE};
			pcstk_pkg::A_PC_VIEW:   rdata = {11'h000, pc_q};
			default:                addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			acc_q     <= 1'b0;
			O_PREADY  <= 1'b0;
			O_PRDATA  <= '0;
			O_PSLVERR <= 1'b0;
		end else if (I_CE) begin
			acc_q     <= I_PSEL && I_PENABLE && !acc_q && !O_PREADY;
			O_PREADY  <= apb_go;
			O_PSLVERR <= apb_go && !addr_ok;
			if (rd) begin
				O_PRDATA <= rdata;
			end
		end
	end

	assign O_PC = pc_q;
endmodule : pc_stack
`default_nettype wire

/* src/pcstk_pkg.sv */
// package: program counter and return stack constants, register map, op codes and carriers
// assumes: one core clock, APB register access with 32-bit data
`default_nettype none
package pcstk_pkg;
	localparam int          PC_W        = 21;
	localparam int          SP_W        = 5;
	localparam int          STK_DEPTH   = 31;
	localparam logic [4:0]  SP_MAX      = 5'h1F;
	localparam logic [20:0] PC_RESET    = 21'h000000;
	localparam logic [20:0] VEC_HIGH    = 21'h000008;
	localparam logic [20:0] VEC_LOW     = 21'h000018;
	localparam logic [20:0] PC_STEP     = 21'h000002;
	localparam logic [7:0]  SP_RESET    = 8'h00;
	localparam int          FULL_BIT    = 7;
	localparam int          UNF_BIT     = 6;
	// register byte addresses
	localparam logic [7:0]  A_PC_LOW    = 8'h00;
	localparam logic [7:0]  A_PC_HLATCH = 8'h04;
	localparam logic [7:0]  A_PC_ULATCH = 8'h08;
	localparam logic [7:0]  A_SP        = 8'h0C;
	localparam logic [7:0]  A_TOS_LOW   = 8'h10;
	localparam logic [7:0]  A_TOS_HIGH  = 8'h14;
	localparam logic [7:0]  A_TOS_UPPER = 8'h18;
	localparam logic [7:0]  A_CTRL      = 8'h1C;
	localparam logic [7:0]  A_PC_VIEW   = 8'h20;

	typedef enum logic [3:0] {
		OP_NONE, OP_STEP, OP_CALL, OP_RELATIVE_CALL, OP_JUMP, OP_BRANCH, OP_IRQ,
		OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT, OP_PUSH, OP_POP
	} flow_op_t;

	typedef struct packed {
		flow_op_t    op;
		logic        fast;
		logic        irq_high;
		logic [20:0] target;
	} flow_req_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] working_register;
		logic [7:0] bank_select_register;
	} core_regs_t;
endpackage : pcstk_pkg
`default_nettype wire

/* src/ret_stack_mem.sv */
// holds the return address entries; registered read port
// assumes: one write and one read per cycle on the core clock
`default_nettype none
module ret_stack_mem #(
	parameter int DEPTH = 31,
	parameter int WIDTH = 21,
	parameter int AW    = 5
) (
	input  wire logic             i_clk,
	input  wire logic             i_ce,
	input  wire logic             i_we,
	input  wire logic [AW-1:0]    i_waddr,
	input  wire logic [WIDTH-1:0] i_wdata,
	input  wire logic [AW-1:0]    i_raddr,
	output var  logic [WIDTH-1:0] o_rdata
);
	// entry 0 of the array backs pointer value 1
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_ce && i_we && i_waddr != '0) begin
			mem[i_waddr - AW'(1)] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			// same-cycle write forwarded so a pop right after a push sees the new entry
			if (i_we && i_waddr == i_raddr && i_raddr != '0) begin
				o_rdata <= i_wdata;
			end else begin
				o_rdata <= (i_raddr == '0) ? '0 : mem[i_raddr - AW'(1)];
			end
		end
	end
endmodule : ret_stack_mem
`default_nettype wire

/* tb/flow_drv.sv */
// partner: decoder model, registers one flow request per cycle
// assumes: bench drives the command at rising edges
`default_nettype none
module flow_drv (
	// clock
	input wire logic			i_clk,
	// bench side
	input wire logic			i_tos_lock,
	input wire pcstk_pkg::flow_req_t	i_cmd,
	// design side
	output var pcstk_pkg::flow_req_t	o_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_req = '0;
	// interrupts held off while software owns the stack top
	always @(posedge i_clk)
		o_req <= (i_tos_lock && i_cmd.op == pcstk_pkg::OP_IRQ) ? '0 : i_cmd;
endmodule : flow_drv
`default_nettype wire

/* tb/pc_stack_sva.sv */
// checker: port-level assertions for the program counter and return stack
// assumes: bound to pc_stack, one clock domain, reset active low
`default_nettype none
module pc_stack_chk (
	// clock and reset
	input wire logic			I_REF_CLK,
	input wire logic			I_RESETN,
	input wire logic			I_CE,
	input wire logic			I_STACK_FAULT_RESET_ENABLE,
	// decoder side
	input wire pcstk_pkg::flow_req_t	I_REQ,
	input wire pcstk_pkg::core_regs_t	I_CORE_REGS,
	input wire logic [20:0]			O_PC,
	input wire logic			O_RESTORE_VALID,
	input wire pcstk_pkg::core_regs_t	O_RESTORE_REGS,
	input wire logic			O_FAULT_RESET,
	// apb
	input wire logic			I_PSEL,
	input wire logic			I_PENABLE,
	input wire logic			I_PWRITE,
	input wire logic [7:0]			I_PADDR,
	input wire logic [31:0]			O_PRDATA,
	input wire logic			O_PREADY
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESETN);
	pcstk_pkg::core_regs_t	sh_q;
	wire logic		save = I_REQ.op == pcstk_pkg::OP_IRQ || (I_REQ.op == pcstk_pkg::OP_CALL && I_REQ.fast);

	// expected shadow contents, only to judge the restore data
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN)
			sh_q <= '0;
		else if (I_CE && save)
			sh_q <= I_CORE_REGS;
	end

	property p_lsb; O_PC[0] == 1'b0; endproperty
	a_lsb: assert property (p_lsb) else $error("pc odd");
	property p_step; I_CE && I_REQ.op == pcstk_pkg::OP_STEP && !I_PSEL |=> O_PC == $past(O_PC) + 21'h2; endproperty
	a_step: assert property (p_step) else $error("step not two");
	property p_jump; I_CE && (I_REQ.op == pcstk_pkg::OP_JUMP || I_REQ.op == pcstk_pkg::OP_BRANCH) && !I_PSEL
		|=> O_PC == ($past(I_REQ.target) & 21'h1FFFFE); endproperty
	a_jump: assert property (p_jump) else $error("jump target");
	property p_irq; I_CE && I_REQ.op == pcstk_pkg::OP_IRQ |=> O_FAULT_RESET
		|| O_PC == ($past(I_REQ.irq_high) ? pcstk_pkg::VEC_HIGH : pcstk_pkg::VEC_LOW); endproperty
	a_irq: assert property (p_irq) else $error("vector");
	property p_fpc; O_FAULT_RESET |-> O_PC == pcstk_pkg::PC_RESET; endproperty
	a_fpc: assert property (p_fpc) else $error("fault pc");
	property p_fen; O_FAULT_RESET |-> $past(I_STACK_FAULT_RESET_ENABLE); endproperty
	a_fen: assert property (p_fen) else $error("fault while disabled");
	property p_rv; I_CE && I_REQ.fast && (I_REQ.op == pcstk_pkg::OP_RETURN || I_REQ.op == pcstk_pkg::OP_RETURN_FROM_INTERRUPT)
		|=> O_RESTORE_VALID; endproperty
	a_rv: assert property (p_rv) else $error("no restore");
	property p_rd; O_RESTORE_VALID |-> O_RESTORE_REGS == sh_q; endproperty
	a_rd: assert property (p_rd) else $error("restore data");
	property p_rdy; $rose(I_PENABLE) && I_PSEL |-> !O_PREADY ##1 !O_PREADY ##1 O_PREADY; endproperty
	a_rdy: assert property (p_rdy) else $error("ready timing");
	property p_spr; O_PREADY && !I_PWRITE && I_PADDR == pcstk_pkg::A_SP |-> O_PRDATA[31:8] == 24'h0 && !O_PRDATA[5];
	endproperty
	a_spr: assert property (p_spr) else $error("pointer read bits");
endmodule : pc_stack_chk

bind pc_stack pc_stack_chk u_pc_stack_chk (.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .I_CE(I_CE),
	.I_STACK_FAULT_RESET_ENABLE(I_STACK_FAULT_RESET_ENABLE), .I_REQ(I_REQ), .I_CORE_REGS(I_CORE_REGS),
	.O_PC(O_PC), .O_RESTORE_VALID(O_RESTORE_VALID), .O_RESTORE_REGS(O_RESTORE_REGS), .O_FAULT_RESET(O_FAULT_RESET),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY));
`default_nettype wire

/* tb/pc_stack_tb_top.sv */
// testbench: flow requests through the decoder model, registers over apb
// assumes: pc_stack with the checker bound, clock enable held high except for one frozen step
`default_nettype none
module pc_stack_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic			clk, rstn, sfre, por, lock, psel, pen, pwr, prdy, perr, rv, fr, e, ce;
	logic [7:0]		paddr;
	logic [31:0]		pwd, prd, r;
	logic [20:0]		pc, p, t;
	pcstk_pkg::flow_req_t	cmd, req;
	pcstk_pkg::core_regs_t	cr, sv, rr;
	int			seed, bad_count, cmp_count, cyc, nf, i;

	pc_stack u_pc_stack (.I_REF_CLK(clk), .I_RESETN(rstn), .I_CE(ce), .I_STACK_FAULT_RESET_ENABLE(sfre),
		.I_POR(por), .I_REQ(req), .I_CORE_REGS(cr), .O_PC(pc), .O_RESTORE_VALID(rv), .O_RESTORE_REGS(rr),
		.O_FAULT_RESET(fr), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd),
		.O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr));
	flow_drv u_flow_drv (.i_clk(clk), .i_tos_lock(lock), .i_cmd(cmd), .o_req(req));

	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask : chk

	function automatic logic [31:0] spv(input logic [1:0] fl, input logic [4:0] s);
		return {24'h0, fl, 1'b0, s};
	endfunction : spv

	// the request stays up until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(n, r, x);
	endtask : rdc

	// request taken two edges after issue; result looked at just after
	task automatic op(input pcstk_pkg::flow_op_t o, input logic f, input logic h, input logic [20:0] tg);
		@(posedge clk);
		cmd <= '{o, f, h, tg};
		@(posedge clk);
		cmd <= '0;
		@(posedge clk);
		#1;
	endtask : op

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (fr === 1'b1)
			nf++;
		if (cyc == 20000) begin
			bad_count++;
			test_done();
		end
	end

	initial begin
		seed = 32'hCD1065F9;
		{rstn, sfre, por, lock, psel, pen, pwr} = '0;
		ce = 1'b1;
		{paddr, pwd, cmd, cr} = '0;
		{bad_count, cmp_count, cyc, nf} = '0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rdc("pointer", pcstk_pkg::A_SP, spv(2'h0, 5'h0));
		apb(1'b0, 8'h3C, 32'h0);
		chk("unmapped", {31'h0, e}, 32'h1);
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			t = 21'($random(seed));
			op(i[0] ? pcstk_pkg::OP_BRANCH : pcstk_pkg::OP_JUMP, 1'b0, 1'b0, t);
			p = t & 21'h1FFFFE;
			chk("jump", {11'h0, pc}, {11'h0, p});
			op(pcstk_pkg::OP_STEP, 1'b0, 1'b0, ~t);
			chk("step", {11'h0, pc}, {11'h0, p + 21'h2});
		end
		@(posedge clk);
		ce <= 1'b0;
		op(pcstk_pkg::OP_STEP, 1'b0, 1'b0, 21'h0);
		chk("frozen", {11'h0, pc}, {11'h0, p + 21'h2});
		@(posedge clk);
		ce <= 1'b1;
		rdc("pc view", pcstk_pkg::A_PC_VIEW, {11'h0, p + 21'h2});
		apb(1'b1, pcstk_pkg::A_PC_HLATCH, 32'hA5);
		apb(1'b1, pcstk_pkg::A_PC_ULATCH, 32'h13);
		apb(1'b1, pcstk_pkg::A_PC_LOW, 32'h67);
		p = 21'h13A566;
		chk("low write", {11'h0, pc}, {11'h0, p});
		t = 21'($random(seed));
		op(pcstk_pkg::OP_CALL, 1'b0, 1'b0, t);
		p = p + 21'h2;
		rdc("pointer", pcstk_pkg::A_SP, spv(2'h0, 5'h1));
		lock <= 1'b1;
		op(pcstk_pkg::OP_IRQ, 1'b0, 1'b1, 21'h0);
		chk("irq held off", {11'h0, pc}, {11'h0, t & 21'h1FFFFE});
		for (i = 0; i < 3; i++)
			rdc("top", pcstk_pkg::A_TOS_LOW + 8'(4 * i), {24'h0, 8'({3'h0, p} >> (8 * i))});
		lock <= 1'b0;
		op(pcstk_pkg::OP_RETURN, 1'b0, 1'b0, 21'h0);
		chk("return", {11'h0, pc}, {11'h0, p});
		chk("no restore", {31'h0, rv}, 32'h0);
		rdc("latch kept", pcstk_pkg::A_PC_HLATCH, 32'hA5);
		apb(1'b1, pcstk_pkg::A_PC_ULATCH, 32'h0);
		rdc("low read", pcstk_pkg::A_PC_LOW, {24'h0, p[7:0]});
		rdc("latch load", pcstk_pkg::A_PC_ULATCH, {27'h0, p[20:16]});
		apb(1'b1, pcstk_pkg::A_SP, 32'h05);
		rdc("pointer write", pcstk_pkg::A_SP, spv(2'h0, 5'h5));
		apb(1'b1, pcstk_pkg::A_SP, 32'h0);
		$display("test latch done");
		op(pcstk_pkg::OP_PUSH, 1'b0, 1'b0, 21'h0);
		rdc("push top", pcstk_pkg::A_TOS_LOW, {24'h0, p[7:0]});
		op(pcstk_pkg::OP_RELATIVE_CALL, 1'b0, 1'b0, 21'h1234);
		op(pcstk_pkg::OP_POP, 1'b0, 1'b0, 21'h0);
		rdc("pop pointer", pcstk_pkg::A_SP, spv(2'h0, 5'h1));
		op(pcstk_pkg::OP_RETURN_WITH_LITERAL, 1'b0, 1'b0, 21'h0);
		chk("return_with_literal", {11'h0, pc}, {11'h0, p});
		for (i = 0; i < 32; i++)
			op(pcstk_pkg::OP_CALL, 1'b0, 1'b0, 21'h200 + 21'(4 * i));
		rdc("full", pcstk_pkg::A_SP, spv(2'h2, 5'h1F));
		rdc("top kept", pcstk_pkg::A_TOS_LOW, 32'h76);
		apb(1'b1, pcstk_pkg::A_SP, 32'h0);
		rdc("cleared", pcstk_pkg::A_SP, spv(2'h0, 5'h0));
		op(pcstk_pkg::OP_RETURN, 1'b0, 1'b0, 21'h0);
		chk("underflow pc", {11'h0, pc}, 32'h0);
		rdc("underflow", pcstk_pkg::A_SP, spv(2'h1, 5'h0));
		apb(1'b1, pcstk_pkg::A_SP, 32'h0);
		$display("test stack done");
		@(posedge clk);
		cr <= 24'($random(seed));
		op(pcstk_pkg::OP_IRQ, 1'b0, 1'b1, 21'h0);
		chk("high vector", {11'h0, pc}, 32'h8);
		cr <= 24'($random(seed));
		op(pcstk_pkg::OP_IRQ, 1'b0, 1'b0, 21'h0);
		sv = cr;
		chk("low vector", {11'h0, pc}, 32'h18);
		cr <= ~sv;
		op(pcstk_pkg::OP_RETURN_FROM_INTERRUPT, 1'b1, 1'b0, 21'h0);
		chk("restore", {31'h0, rv}, 32'h1);
		chk("shadow", {8'h0, rr}, {8'h0, sv});
		apb(1'b1, pcstk_pkg::A_SP, 32'h0);
		@(posedge clk);
		sfre <= 1'b1;
		for (i = 0; i < 31; i++)
			op(pcstk_pkg::OP_CALL, 1'b0, 1'b0, 21'h40);
		chk("fault pc", {11'h0, pc}, 32'h0);
		rdc("fault full", pcstk_pkg::A_SP, spv(2'h2, 5'h0));
		rdc("ctrl", pcstk_pkg::A_CTRL, 32'h1);
		op(pcstk_pkg::OP_RETURN, 1'b0, 1'b0, 21'h0);
		rdc("fault underflow", pcstk_pkg::A_SP, spv(2'h3, 5'h0));
		chk("fault count", 32'(nf), 32'h2);
		@(posedge clk);
		por <= 1'b1;
		@(posedge clk);
		por <= 1'b0;
		rdc("power on", pcstk_pkg::A_SP, spv(2'h0, 5'h0));
		$display("test fault done");
		test_done();
	end
endmodule : pc_stack_tb_top
`default_nettype wire
